/* File: common/opmode_clk_defines.svh */
// register map, field positions and timing counts of the mode controller
`ifndef OPMODE_CLK_DEFINES_SVH
`define OPMODE_CLK_DEFINES_SVH
`define OSC_MODE_CTRL_ADDR 8'h95
`define OSC_MODE_CTRL_RESET 8'h00
`define HIGH_OSC_STOP_BIT 1
`define CLOCK_SEL_SLOW_BIT 2
`define OP_MODE_LSB 3
`define OP_MODE_MSB 4
`define OP_MODE_NORMAL 2'h0
`define OP_MODE_POWER_DOWN 2'h1
`define OP_MODE_GREEN 2'h2
`define OP_MODE_RESERVED 2'h3
`define WARM_RESET_CLKS 11'h400
`define WARM_WAKE_CLKS 11'h040
`define SLOW_DIV_LIMIT 8'h03
`endif

/* File: common/opmode_clk_pkg.sv */
// types of the operating-mode clock controller
package opmode_clk_pkg;
    // gray codes along warm, run, green, sleep, wake
    typedef enum logic [2:0] {
        ST_WARM = 3'h0,
        ST_RUN = 3'h1,
        ST_GREEN = 3'h3,
        ST_SLEEP = 3'h2,
        ST_WAKE = 3'h6
    } state_t;
endpackage

/* File: hdl/operating_mode_clock_control.sv */
// operating-mode and oscillator controller with mode register
// How it works
// - slow mode instruction clock is low-speed oscillator divided by four only
// - low oscillator stops only in power down or slow-entered green without watchdog
// - no separate switch-off for low oscillator, only mode bits and watchdog
// - mode field bits 4:3: 00 normal, 01 power down, 10 green, 11 reserved
// - stop bit 1 halts high oscillator when set, low oscillator keeps running in slow mode
// - bit 2 selects high clock when 0, low clock slow mode when 1
// - after reset wait 1024 high oscillator clocks before running
// - power-down wake waits 64 high oscillator clocks before execution resumes
// - power down stops both oscillators, execution and all peripherals
// - green mode halts execution but keeps enabled pwm running
// - after reset start in normal mode on high clock, halted until the warm-up ends
// - slow select alone leaves high oscillator running until stop bit set
// - green wake returns to the mode held before entry
// - power-down bit set by write, cleared by hardware on wake
// - power down left only on port 0 or enabled port 1 level change
// - power-down wake resumes in normal mode unless a register write lands in the wake cycle
// - stopping high clock in normal mode acts as power down, port wake
// - low oscillator feeds watchdog clock and slow system clock
// - green bit cleared by hardware on wake
// - green wakes on port change, timer overflow, conversion done, comparator
// - normal instruction clock is high oscillator divided by 2 to 256
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module operating_mode_clock_control (
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic HIGH_OSC_I,
    input wire logic LOW_OSC_I,
    input wire logic [6:0] PORT0_I,
    input wire logic [6:0] PORT1_I,
    input wire logic [6:0] PORT1_WAKE_EN_I,
    input wire logic TIMER_OVF_I,
    input wire logic ADC_DONE_I,
    input wire logic CMP_TRIG_I,
    input wire logic PWM_EN_I,
    input wire logic WDT_EN_I,
    input wire logic [2:0] CPU_DIV_SEL_I,
    output logic CPU_RUN_O,
    output logic CPU_CLK_EN_O,
    output logic HIGH_OSC_RUN_O,
    output logic LOW_OSC_RUN_O,
    output logic WDT_CLK_EN_O,
    output logic TIMER_ACT_O,
    output logic PWM_ACT_O,
    output logic ADC_ACT_O,
    output logic CMP_ACT_O
);
    `include "opmode_clk_defines.svh"

    localparam int NSYNC = 16;

    // instruction divider limit for the selected source
    function automatic logic [7:0] div_limit(input logic slow, input logic [2:0] sel);
        logic [8:0] full;
        full = 9'h002 << sel;
        if (slow) begin
            div_limit = `SLOW_DIV_LIMIT;
        end else begin
            div_limit = 8'(full - 9'h001);
        end
    endfunction

    opmode_clk_pkg::state_t st;
    opmode_clk_pkg::state_t next_st;
    logic [1:0] op_mode;
    logic clock_select_slow;
    logic high_osc_stop;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] filt;
    logic [NSYNC-1:0] chg;
    logic hosc_tick;
    logic losc_tick;
    logic port_wake;
    logic green_wake;
    logic reg_wr;
    logic [10:0] warm_cnt;
    logic [7:0] div_cnt;
    logic sel_slow;
    logic src_tick;
    logic src_run;
    logic hosc_on;
    logic losc_on;
    logic div_hit;

    assign pin_raw = {LOW_OSC_I, HIGH_OSC_I, PORT1_I, PORT0_I};
    assign reg_wr = WR_I && (ADDR_I == `OSC_MODE_CTRL_ADDR);

    // three-stage synchronisers on every pin input
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else if (CE_I) begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accepted level once second and third stages agree
    // a pin idling high shows one change after reset, swallowed while warming up
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_filt
            assign chg[gi] = (s2[gi] == s3[gi]) && (s2[gi] != filt[gi]);
            always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    filt[gi] <= 1'b0;
                end else if (CE_I && chg[gi]) begin
                    filt[gi] <= s2[gi];
                end
            end
        end
    endgenerate

    // rising edges of the oscillators, and port wake events
    assign hosc_tick = chg[14] && s2[14] && hosc_on;
    assign losc_tick = chg[15] && s2[15] && losc_on;
    assign port_wake = (|chg[6:0]) || (|(chg[13:7] & PORT1_WAKE_EN_I));
    assign green_wake = port_wake || TIMER_OVF_I || ADC_DONE_I || CMP_TRIG_I;

    // oscillator enables from mode bits and watchdog only
    assign hosc_on = (st != opmode_clk_pkg::ST_SLEEP) && !high_osc_stop;
    assign losc_on = (st != opmode_clk_pkg::ST_SLEEP) &&
        !((st == opmode_clk_pkg::ST_GREEN) && clock_select_slow && !WDT_EN_I);

    // mode sequencer
    always_comb begin
        next_st = st;
        case (st)
            opmode_clk_pkg::ST_WARM: begin
                if (hosc_tick && (warm_cnt == `WARM_RESET_CLKS - 11'h001)) begin
                    next_st = opmode_clk_pkg::ST_RUN;
                end
            end
            opmode_clk_pkg::ST_RUN: begin
                if (op_mode == `OP_MODE_POWER_DOWN) begin
                    next_st = opmode_clk_pkg::ST_SLEEP;
                end else if (op_mode == `OP_MODE_GREEN) begin
                    next_st = opmode_clk_pkg::ST_GREEN;
                end else if (high_osc_stop && !clock_select_slow && !sel_slow) begin
                    next_st = opmode_clk_pkg::ST_SLEEP;
                end
            end
            opmode_clk_pkg::ST_GREEN: begin
                if (green_wake) begin
                    next_st = opmode_clk_pkg::ST_RUN;
                end
            end
            opmode_clk_pkg::ST_SLEEP: begin
                if (port_wake) begin
                    next_st = opmode_clk_pkg::ST_WAKE;
                end
            end
            opmode_clk_pkg::ST_WAKE: begin
                if (hosc_tick && (warm_cnt == `WARM_WAKE_CLKS - 11'h001)) begin
                    next_st = opmode_clk_pkg::ST_RUN;
                end
            end
            default: begin
                next_st = opmode_clk_pkg::ST_WARM;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            st <= opmode_clk_pkg::ST_WARM;
        end else if (CE_I) begin
            st <= next_st;
        end
    end

    // warm-up counter of high oscillator clocks
    // counting edges, not time, keeps the warm-up exact at any oscillator rate slow enough to pass the synchronisers and level filter
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            warm_cnt <= '0;
        end else if (CE_I) begin
            if (next_st != st) begin
                warm_cnt <= '0;
            end else if (hosc_tick) begin
                warm_cnt <= warm_cnt + 11'h001;
            end
        end
    end

    // mode register; a write wins over a hardware clear
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            op_mode <= `OP_MODE_NORMAL;
            clock_select_slow <= 1'b0;
            high_osc_stop <= 1'b0;
        end else if (CE_I) begin
            if (reg_wr) begin
                op_mode <= WDATA_I[`OP_MODE_MSB:`OP_MODE_LSB];
                clock_select_slow <= WDATA_I[`CLOCK_SEL_SLOW_BIT];
                high_osc_stop <= WDATA_I[`HIGH_OSC_STOP_BIT];
            end else if (st == opmode_clk_pkg::ST_SLEEP &&
                         next_st == opmode_clk_pkg::ST_WAKE) begin
                op_mode <= `OP_MODE_NORMAL;
                clock_select_slow <= 1'b0;
                high_osc_stop <= 1'b0;
            end else if (st == opmode_clk_pkg::ST_GREEN && next_st == opmode_clk_pkg::ST_RUN) begin
                op_mode <= `OP_MODE_NORMAL;
            end
        end
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RDATA_O <= '0;
        end else if (CE_I) begin
            if (RD_I && ADDR_I == `OSC_MODE_CTRL_ADDR) begin
                RDATA_O <= {3'h0, op_mode, clock_select_slow, high_osc_stop, 1'b0};
            end else begin
                RDATA_O <= '0;
            end
        end
    end

    // instruction divider on the active source
    assign src_tick = sel_slow ? losc_tick : hosc_tick;
    assign src_run = sel_slow ? losc_on : hosc_on;
    assign div_hit = src_tick && (div_cnt >= div_limit(sel_slow, CPU_DIV_SEL_I));

    // source change only at a boundary or with the old source dead
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            div_cnt <= '0;
            sel_slow <= 1'b0;
        end else if (CE_I) begin
            if (div_hit || !src_run) begin
                div_cnt <= '0;
                sel_slow <= clock_select_slow;
            end else if (src_tick) begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    // registered activity outputs
    always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            CPU_RUN_O <= 1'b0;
            CPU_CLK_EN_O <= 1'b0;
            HIGH_OSC_RUN_O <= 1'b1;
            LOW_OSC_RUN_O <= 1'b1;
            WDT_CLK_EN_O <= 1'b0;
            TIMER_ACT_O <= 1'b0;
            PWM_ACT_O <= 1'b0;
            ADC_ACT_O <= 1'b0;
            CMP_ACT_O <= 1'b0;
        end else if (CE_I) begin
            CPU_RUN_O <= (st == opmode_clk_pkg::ST_RUN);
            CPU_CLK_EN_O <= div_hit && (st == opmode_clk_pkg::ST_RUN);
            HIGH_OSC_RUN_O <= hosc_on;
            LOW_OSC_RUN_O <= losc_on;
            WDT_CLK_EN_O <= losc_tick;
            TIMER_ACT_O <= (st != opmode_clk_pkg::ST_SLEEP) && (st != opmode_clk_pkg::ST_WAKE);
            PWM_ACT_O <= PWM_EN_I && (st != opmode_clk_pkg::ST_SLEEP) &&
                (st != opmode_clk_pkg::ST_WAKE);
            ADC_ACT_O <= (st != opmode_clk_pkg::ST_SLEEP) && (st != opmode_clk_pkg::ST_WAKE);
            CMP_ACT_O <= (st != opmode_clk_pkg::ST_SLEEP) && (st != opmode_clk_pkg::ST_WAKE);
        end
    end

    // checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RESET_N_I);

    a_sleep_all_off: assert property (
        (CE_I && st == opmode_clk_pkg::ST_SLEEP) |=>
            (!HIGH_OSC_RUN_O && !LOW_OSC_RUN_O && !CPU_RUN_O && !PWM_ACT_O && !TIMER_ACT_O))
        else $error("power down left something running");

    a_warm_reset_len: assert property (
        (CE_I && st == opmode_clk_pkg::ST_WARM && next_st == opmode_clk_pkg::ST_RUN) |->
            (hosc_tick && warm_cnt == 11'h3ff))
        else $error("reset warm-up not 1024 clocks");

    a_warm_wake_len: assert property (
        (CE_I && st == opmode_clk_pkg::ST_WAKE && next_st == opmode_clk_pkg::ST_RUN) |->
            (hosc_tick && warm_cnt == 11'h03f))
        else $error("wake warm-up not 64 clocks");

    a_pd_wake_normal: assert property (
        (CE_I && !reg_wr && st == opmode_clk_pkg::ST_SLEEP && port_wake) |=>
            (op_mode == 2'h0 && !clock_select_slow && st == opmode_clk_pkg::ST_WAKE))
        else $error("power-down wake did not restore normal");

    a_green_return: assert property (
        (CE_I && !reg_wr && st == opmode_clk_pkg::ST_GREEN && green_wake) |=>
            (st == opmode_clk_pkg::ST_RUN && op_mode == 2'h0 &&
             clock_select_slow == $past(clock_select_slow)))
        else $error("green wake did not return to prior mode");

    a_low_osc_stop: assert property (
        (CE_I && st == opmode_clk_pkg::ST_GREEN && clock_select_slow && !WDT_EN_I) |=>
            !LOW_OSC_RUN_O)
        else $error("low oscillator kept running in slow green");

    a_high_osc_stop: assert property (
        (CE_I && high_osc_stop) |=> !HIGH_OSC_RUN_O)
        else $error("high oscillator runs with stop set");

    a_slow_divide: assert property (
        (CE_I && sel_slow && src_tick && src_run && !div_hit) |=> (div_cnt <= 8'h03))
        else $error("slow divider beyond four");

    a_reserved_normal: assert property (
        (CE_I && st == opmode_clk_pkg::ST_RUN && op_mode == 2'h3 && !high_osc_stop) |=>
            (st == opmode_clk_pkg::ST_RUN))
        else $error("reserved mode left normal running");

    a_green_pwm: assert property (
        (CE_I && st == opmode_clk_pkg::ST_GREEN && PWM_EN_I) |=> (PWM_ACT_O && !CPU_RUN_O))
        else $error("green mode pwm or cpu wrong");

    // wake sources, oscillator gating and clock switching
    a_sleep_port_only: assert property (
        (CE_I && st == opmode_clk_pkg::ST_SLEEP && !port_wake) |=>
            (st == opmode_clk_pkg::ST_SLEEP))
        else $error("power down left without a port change");

    a_green_stays: assert property (
        (CE_I && st == opmode_clk_pkg::ST_GREEN && !green_wake) |=>
            (st == opmode_clk_pkg::ST_GREEN))
        else $error("green mode left without a wake source");

    a_stop_normal_sleep: assert property (
        (CE_I && st == opmode_clk_pkg::ST_RUN && high_osc_stop && !clock_select_slow &&
            !sel_slow && op_mode != `OP_MODE_GREEN) |=> (st == opmode_clk_pkg::ST_SLEEP))
        else $error("high clock stopped in normal mode without power down");

    a_low_osc_runs: assert property (
        (CE_I && st == opmode_clk_pkg::ST_RUN) |=> LOW_OSC_RUN_O)
        else $error("low oscillator stopped while running");

    a_switch_boundary: assert property (
        (CE_I && src_run && !div_hit) |=> (sel_slow == $past(sel_slow)))
        else $error("clock source switched inside a divider period");

    a_wdt_tick: assert property (
        (CE_I && losc_tick) |=> WDT_CLK_EN_O)
        else $error("watchdog missed a low oscillator edge");

    a_pulse_in_run: assert property (
        (CE_I && CPU_CLK_EN_O) |-> CPU_RUN_O)
        else $error("instruction pulse while execution halted");

    // main scenarios reached
    c_enter_sleep: cover property (st == opmode_clk_pkg::ST_RUN ##1
        st == opmode_clk_pkg::ST_SLEEP);
    c_green_wake: cover property (st == opmode_clk_pkg::ST_GREEN ##1 st == opmode_clk_pkg::ST_RUN);
    c_wake_done: cover property (st == opmode_clk_pkg::ST_WAKE ##1 st == opmode_clk_pkg::ST_RUN);
    c_slow_pulse: cover property (sel_slow && CPU_CLK_EN_O);
    c_green_low_off: cover property (st == opmode_clk_pkg::ST_GREEN && !LOW_OSC_RUN_O);
endmodule

/* File: dv/tb.sv */
// self-checking bench of the operating-mode clock controller
`timescale 1ns/1ns
module tb;
    logic CLOCK_I, RESET_N_I, WR_I, RD_I, HIGH_OSC_I, LOW_OSC_I;
    logic TIMER_OVF_I, ADC_DONE_I, CMP_TRIG_I, PWM_EN_I, WDT_EN_I;
    logic [7:0] ADDR_I, WDATA_I, RDATA_O, rd;
    logic [6:0] PORT0_I, PORT1_I, PORT1_WAKE_EN_I;
    logic [2:0] CPU_DIV_SEL_I;
    logic CPU_RUN_O, CPU_CLK_EN_O, HIGH_OSC_RUN_O, LOW_OSC_RUN_O, WDT_CLK_EN_O;
    logic TIMER_ACT_O, PWM_ACT_O, ADC_ACT_O, CMP_ACT_O, osc_on, ce;
    logic [15:0] hi_edges, lo_edges, lfsr, a, b;
    int num_errors, n_tests, osc_cnt;

    operating_mode_clock_control u_operating_mode_clock_control (
        .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .CE_I(ce), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .HIGH_OSC_I(HIGH_OSC_I), .LOW_OSC_I(LOW_OSC_I), .PORT0_I(PORT0_I),
        .PORT1_I(PORT1_I), .PORT1_WAKE_EN_I(PORT1_WAKE_EN_I), .TIMER_OVF_I(TIMER_OVF_I),
        .ADC_DONE_I(ADC_DONE_I), .CMP_TRIG_I(CMP_TRIG_I), .PWM_EN_I(PWM_EN_I),
        .WDT_EN_I(WDT_EN_I), .CPU_DIV_SEL_I(CPU_DIV_SEL_I), .CPU_RUN_O(CPU_RUN_O),
        .CPU_CLK_EN_O(CPU_CLK_EN_O), .HIGH_OSC_RUN_O(HIGH_OSC_RUN_O),
        .LOW_OSC_RUN_O(LOW_OSC_RUN_O), .WDT_CLK_EN_O(WDT_CLK_EN_O),
        .TIMER_ACT_O(TIMER_ACT_O), .PWM_ACT_O(PWM_ACT_O), .ADC_ACT_O(ADC_ACT_O),
        .CMP_ACT_O(CMP_ACT_O)
    );

    // 100 MHz clock
    initial begin
        CLOCK_I = 1'b0;
        forever #5 CLOCK_I = ~CLOCK_I;
    end

    // oscillator pins: high one toggles every 4 cycles, low one every 16, only while enabled
    always @(posedge CLOCK_I) begin
        if (osc_on) begin
            osc_cnt <= osc_cnt + 1;
            if (osc_cnt % 4 == 3 && HIGH_OSC_RUN_O === 1'b1) begin
                HIGH_OSC_I <= ~HIGH_OSC_I;
                hi_edges <= hi_edges + {15'h0, ~HIGH_OSC_I};
            end
            if (osc_cnt % 16 == 15 && LOW_OSC_RUN_O === 1'b1) begin
                LOW_OSC_I <= ~LOW_OSC_I;
                lo_edges <= lo_edges + {15'h0, ~LOW_OSC_I};
            end
        end
    end

    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // high-osc edges per instruction pulse in normal mode
    function automatic logic [15:0] div_edges(input int sel);
        return 16'h2 << sel;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g,
                       input int tol = 0);
        logic ok;
        ok = (g + tol >= e) && (g <= e + tol);
        n_tests++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic print_verdict;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLOCK_I);
        #1;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge CLOCK_I);
        ADDR_I <= ad;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLOCK_I);
        WR_I <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] ad, output logic [7:0] d);
        @(posedge CLOCK_I);
        ADDR_I <= ad;
        RD_I <= 1'b1;
        @(posedge CLOCK_I);
        RD_I <= 1'b0;
        #1 d = RDATA_O;
    endtask

    task automatic rchk(input string nm, input logic [7:0] e);
        rdr(8'h95, rd);
        chk(nm, {8'h0, e}, {8'h0, rd});
    endtask

    task automatic pulse(input int s);
        @(posedge CLOCK_I);
        TIMER_OVF_I <= (s == 0);
        ADC_DONE_I <= (s == 1);
        CMP_TRIG_I <= (s == 2);
        @(posedge CLOCK_I);
        {TIMER_OVF_I, ADC_DONE_I, CMP_TRIG_I} <= 3'h0;
    endtask

    // high-osc edges from oscillator enable to execution, bounded
    task automatic warm(output logic [15:0] d);
        int i;
        logic seen;
        seen = 1'b0;
        d = 16'h0;
        for (i = 0; i < 10000 && CPU_RUN_O !== 1'b1; i++) begin
            cyc(1);
            if (HIGH_OSC_RUN_O === 1'b1 && !seen) begin
                seen = 1'b1;
                d = hi_edges;
            end
        end
        if (CPU_RUN_O !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
        d = hi_edges - d;
    endtask

    // osc edges between the 2nd and 3rd instruction pulse
    task automatic period(output logic [15:0] dh, output logic [15:0] dl);
        int i, k;
        k = 0;
        dh = 16'h0;
        dl = 16'h0;
        for (i = 0; i < 30000 && k < 3; i++) begin
            cyc(1);
            if (CPU_CLK_EN_O === 1'b1) begin
                k++;
                dh = (k == 2) ? hi_edges : hi_edges - dh;
                dl = (k == 2) ? lo_edges : lo_edges - dl;
            end
        end
        if (k < 3) begin
            num_errors++;
            print_verdict();
        end
    endtask

    // main sequence
    initial begin
        {WR_I, RD_I, HIGH_OSC_I, LOW_OSC_I, osc_on, RESET_N_I} = 6'h0;
        {TIMER_OVF_I, ADC_DONE_I, CMP_TRIG_I, PWM_EN_I, WDT_EN_I} = 5'h03;
        ce = 1'b1;
        {ADDR_I, WDATA_I, PORT0_I, PORT1_I, PORT1_WAKE_EN_I} = 37'h0;
        CPU_DIV_SEL_I = 3'h0;
        {hi_edges, lo_edges, osc_cnt, num_errors, n_tests} = 128'h0;
        lfsr = 16'hd387;
        repeat (12) @(posedge CLOCK_I);
        RESET_N_I <= 1'b1;
        osc_on <= 1'b1;
        cyc(1);
        chk("run_at_release", 0, CPU_RUN_O);
        warm(a);
        chk("reset_warm", 1024, a, 1);
        chk("normal_oscs", 3, {HIGH_OSC_RUN_O, LOW_OSC_RUN_O});
        chk("normal_acts", 7, {TIMER_ACT_O, ADC_ACT_O, CMP_ACT_O});
        rchk("reg_reset", 8'h00);
        // clock enable low freezes the register against writes
        ce <= 1'b0;
        wr(8'h95, 8'h04);
        ce <= 1'b1;
        rchk("ce_freeze", 8'h00);
        // unmapped place reads zero and ignores writes
        lfsr = next_rand(lfsr);
        a = (lfsr[7:0] == 8'h95) ? 16'h96 : {8'h0, lfsr[7:0]};
        wr(a[7:0], lfsr[15:8]);
        rdr(a[7:0], rd);
        chk("unmapped_rd", 0, {8'h0, rd});
        rchk("unmapped_wr", 8'h00);
        for (int i = 0; i < 3; i++) begin
            lfsr = next_rand(lfsr);
            wr(8'h95, {5'h0, lfsr[0], 2'h0});
            rchk("clk_sel_rw", {5'h0, lfsr[0], 2'h0});
        end
        wr(8'h95, 8'h00);
        for (int s = 0; s < 8; s++) begin
            CPU_DIV_SEL_I <= s[2:0];
            period(a, b);
            chk("normal_div", div_edges(s), a);
        end
        CPU_DIV_SEL_I <= 3'h0;
        wr(8'h95, 8'h04);
        cyc(4);
        chk("slow_keeps_high", 1, HIGH_OSC_RUN_O);
        period(a, b);
        chk("slow_div", 4, b);
        a = 0;
        for (int i = 0; i < 320; i++) begin
            cyc(1);
            a = a + {15'h0, WDT_CLK_EN_O};
        end
        chk("wdt_ticks", 10, a, 1);
        wr(8'h95, 8'h06);
        cyc(4);
        chk("stop_high", 1, {HIGH_OSC_RUN_O, LOW_OSC_RUN_O});
        period(a, b);
        chk("slow_div_stop", 4, b);
        for (int s = 0; s < 3; s++) begin
            lfsr = next_rand(lfsr);
            WDT_EN_I <= s[0];
            PWM_EN_I <= lfsr[1];
            wr(8'h95, 8'h16);
            cyc(4);
            chk("green_halt", 0, CPU_RUN_O);
            chk("green_low", s[0], LOW_OSC_RUN_O);
            chk("green_pwm", lfsr[1], PWM_ACT_O);
            pulse(s);
            cyc(4);
            chk("green_wake", 1, CPU_RUN_O);
            rchk("green_back_slow", 8'h06);
        end
        wr(8'h95, 8'h00);
        cyc(50);
        wr(8'h95, 8'h10);
        cyc(4);
        chk("green_n_halt", 0, CPU_RUN_O);
        PORT0_I <= PORT0_I ^ 7'h01;
        cyc(8);
        chk("green_port_wake", 1, CPU_RUN_O);
        rchk("green_back_norm", 8'h00);
        // power down entered from slow mode
        PWM_EN_I <= 1'b1;
        lfsr = next_rand(lfsr);
        PORT1_WAKE_EN_I <= (lfsr[6:0] & 7'h77) | 7'h01;
        wr(8'h95, 8'h04);
        wr(8'h95, 8'h0c);
        cyc(4);
        chk("sleep_outs", 0, {CPU_RUN_O, HIGH_OSC_RUN_O, LOW_OSC_RUN_O, TIMER_ACT_O,
            PWM_ACT_O, ADC_ACT_O, CMP_ACT_O});
        for (int s = 0; s < 3; s++) pulse(s);
        PORT1_I <= PORT1_I ^ 7'h08;
        cyc(10);
        chk("sleep_stays", 0, {CPU_RUN_O, HIGH_OSC_RUN_O});
        PORT1_I <= PORT1_I ^ 7'h01;
        warm(a);
        chk("wake_warm", 64, a, 1);
        chk("wake_acts", 15, {TIMER_ACT_O, PWM_ACT_O, ADC_ACT_O, CMP_ACT_O});
        rchk("sleep_bit_clr", 8'h00);
        wr(8'h95, 8'h02);
        cyc(4);
        chk("stop_in_normal", 0, {CPU_RUN_O, HIGH_OSC_RUN_O});
        PORT0_I <= PORT0_I ^ 7'h40;
        warm(a);
        chk("stop_wake_warm", 64, a, 1);
        rchk("stop_wake_clr", 8'h00);
        wr(8'h95, 8'h18);
        cyc(20);
        chk("reserved_runs", 7, {CPU_RUN_O, HIGH_OSC_RUN_O, LOW_OSC_RUN_O});
        rchk("reserved_rd", 8'h18);
        wr(8'h95, 8'h00);
        cyc(4);
        print_verdict();
    end
endmodule
